// ### core/parallel_to_serial_shifter.sv
`timescale 1ns/1ps
// Function
// - eight stages form one shift chain
// - last stage driven true and inverted
// - load low copies parallel inputs
// - load low overrides every clock edge
// - stages follow parallel inputs while loading
// - rising clock shifts toward last stage
// - first stage captures serial input
// - shift clock is OR of both
// - either clock held high blocks shifting
// - rising inhibit with clock low shifts
// - static clock levels change nothing
module parallel_to_serial_shifter
    import shifter_pkg::*;
#(
    parameter int STAGES = STAGE_COUNT,
    parameter int DEPTH  = FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic              I_MCLK,
    input  wire logic              I_RST_N,
    // Controller pins
    input  wire logic              I_LOAD_N,
    input  wire logic              I_SERIAL_IN,
    input  wire logic              I_SHIFT_CLOCK_A,
    input  wire logic              I_SHIFT_CLOCK_B,
    input  wire logic [STAGES-1:0] I_PARALLEL_IN,
    // Stage outputs
    output logic [STAGES-1:0]      O_STAGE_BITS,
    output logic                   O_LAST_STAGE_OUT,
    output logic                   O_LAST_STAGE_OUT_N,
    // Shifted-out bit stream
    output logic                   O_STREAM_VALID,
    input  wire logic              I_STREAM_READY,
    output logic [STREAM_WIDTH-1:0] O_STREAM_DATA,
    output logic                   O_STREAM_SPACE
);
    logic              rst_meta_r, rst_sync_r;
    shift_ctl_t        ctl;
    logic [STAGES-1:0] stage_r, stage_nxt;
    logic              last_r, last_nxt;
    logic              last_n_r, last_n_nxt;
    logic              prev_clk_r, prev_clk_nxt;
    logic              space_r;
    logic              clk_or, shift_edge;
    stream_word_t      push_word, pop_word;
    logic              fifo_in_ready, fifo_out_valid;
    logic              valid_r, valid_nxt, pop_take;
    logic [STREAM_WIDTH-1:0] data_r, data_nxt;

    // Reset release synchroniser
    always_ff @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rst_meta_r <= SYNC_RST_VAL;
            rst_sync_r <= SYNC_RST_VAL;
        end else begin
            rst_meta_r <= 1'h1;
            rst_sync_r <= rst_meta_r;
        end
    end

    assign ctl = '{load_n:        I_LOAD_N,
                   serial_in:     I_SERIAL_IN,
                   shift_clock_a: I_SHIFT_CLOCK_A,
                   shift_clock_b: I_SHIFT_CLOCK_B};

    assign clk_or     = ctl.shift_clock_a | ctl.shift_clock_b;
    assign shift_edge = ctl.load_n && clk_or && !prev_clk_r;

    always_comb begin
        prev_clk_nxt = clk_or;
        if (!ctl.load_n) begin
            stage_nxt = I_PARALLEL_IN;
        end else if (shift_edge) begin
            stage_nxt = {stage_r[STAGES-2:0], ctl.serial_in};
        end else begin
            stage_nxt = stage_r;
        end
        last_nxt = stage_nxt[STAGES-1];
        last_n_nxt = !stage_nxt[STAGES-1];
    end

    // Reset value stands in for the undefined power-up content
    always_ff @(posedge I_MCLK or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            stage_r    <= STAGES'(STAGE_RESET);
            last_r     <= 1'h0;
            last_n_r   <= 1'h1;
            prev_clk_r <= PREV_CLK_RST;
            space_r    <= 1'h0;
        end else begin
            stage_r    <= stage_nxt;
            last_r     <= last_nxt;
            last_n_r   <= last_n_nxt;
            prev_clk_r <= prev_clk_nxt;
            space_r    <= fifo_in_ready;
        end
    end

    assign O_STAGE_BITS       = stage_r;
    assign O_LAST_STAGE_OUT   = last_r;
    assign O_LAST_STAGE_OUT_N = last_n_r;
    assign O_STREAM_SPACE     = space_r;

    // Bit leaving the last stage on each shift
    assign push_word.bits = STREAM_WIDTH'(stage_r[STAGES-1]);

    stream_fifo #(
        .WIDTH (STREAM_WIDTH),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk       (I_MCLK),
        .rst_n     (rst_sync_r),
        .in_valid  (shift_edge),
        .in_ready  (fifo_in_ready),
        .in_data   (push_word.bits),
        .out_valid (fifo_out_valid),
        .out_ready (pop_take),
        .out_data  (pop_word.bits)
    );

    // Registered output stage of the stream
    assign pop_take = fifo_out_valid && (!valid_r || I_STREAM_READY);

    always_comb begin
        valid_nxt = valid_r;
        data_nxt  = data_r;
        if (pop_take) begin
            valid_nxt = 1'h1;
            data_nxt  = pop_word.bits;
        end else if (I_STREAM_READY) begin
            valid_nxt = 1'h0;
        end
    end

    always_ff @(posedge I_MCLK or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            valid_r <= 1'h0;
            data_r  <= '0;
        end else begin
            valid_r <= valid_nxt;
            data_r  <= data_nxt;
        end
    end

    assign O_STREAM_VALID = valid_r;
    assign O_STREAM_DATA  = data_r;

    chk_load_follows: assert property (
        @(posedge I_MCLK) disable iff (!rst_sync_r)
        !I_LOAD_N |=> O_STAGE_BITS == $past(I_PARALLEL_IN))
        else $error("stages did not follow parallel inputs");

    chk_load_overrides: assert property (
        @(posedge I_MCLK) disable iff (!rst_sync_r)
        (!I_LOAD_N && (I_SHIFT_CLOCK_A || I_SHIFT_CLOCK_B)) |=>
            O_STAGE_BITS == $past(I_PARALLEL_IN))
        else $error("clock edge disturbed a load");

    chk_shift_step: assert property (
        @(posedge I_MCLK) disable iff (!rst_sync_r)
        shift_edge |=> O_STAGE_BITS ==
            {$past(O_STAGE_BITS[STAGES-2:0]), $past(I_SERIAL_IN)})
        else $error("shift did not move stages");

    chk_static_hold: assert property (
        @(posedge I_MCLK) disable iff (!rst_sync_r)
        (I_LOAD_N && !shift_edge) |=> $stable(O_STAGE_BITS))
        else $error("stages changed without an edge");

    chk_inhibit_hold: assert property (
        @(posedge I_MCLK) disable iff (!rst_sync_r)
        (I_SHIFT_CLOCK_A && I_LOAD_N) ##1 (I_SHIFT_CLOCK_A && I_LOAD_N)
            |=> $stable(O_STAGE_BITS))
        else $error("shift while clock held high");

    chk_inhibit_edge: assert property (
        @(posedge I_MCLK) disable iff (!rst_sync_r)
        (!I_SHIFT_CLOCK_A && !I_SHIFT_CLOCK_B) ##1
            (I_LOAD_N && I_SHIFT_CLOCK_B && !I_SHIFT_CLOCK_A)
            |=> O_STAGE_BITS[0] == $past(I_SERIAL_IN)
                && O_STAGE_BITS[STAGES-1:1] == $past(O_STAGE_BITS[STAGES-2:0]))
        else $error("rising inhibit did not shift");

    chk_outputs_pair: assert property (
        @(posedge I_MCLK) disable iff (!rst_sync_r)
        O_LAST_STAGE_OUT_N == !O_LAST_STAGE_OUT)
        else $error("complement output mismatch");

    chk_last_stage: assert property (
        @(posedge I_MCLK) disable iff (!rst_sync_r)
        O_LAST_STAGE_OUT == O_STAGE_BITS[STAGES-1])
        else $error("last stage output not stage eight");

    chk_clock_b_hold: assert property (
        @(posedge I_MCLK) disable iff (!rst_sync_r)
        (I_SHIFT_CLOCK_B && I_LOAD_N) ##1 (I_SHIFT_CLOCK_B && I_LOAD_N)
            |=> $stable(O_STAGE_BITS))
        else $error("shift while pin B held high");

    chk_clock_a_edge: assert property (
        @(posedge I_MCLK) disable iff (!rst_sync_r)
        (!I_SHIFT_CLOCK_A && !I_SHIFT_CLOCK_B) ##1 (I_LOAD_N && I_SHIFT_CLOCK_A)
            |=> O_STAGE_BITS == {$past(O_STAGE_BITS[STAGES-2:0]), $past(I_SERIAL_IN)})
        else $error("rising pin A did not shift");

    chk_last_shift: assert property (
        @(posedge I_MCLK) disable iff (!rst_sync_r)
        shift_edge |=> O_LAST_STAGE_OUT == $past(O_STAGE_BITS[STAGES-2])
            && O_LAST_STAGE_OUT_N == !$past(O_STAGE_BITS[STAGES-2]))
        else $error("last stage missed the shifted bit");

    chk_load_complement: assert property (
        @(posedge I_MCLK) disable iff (!rst_sync_r)
        !I_LOAD_N |=> O_LAST_STAGE_OUT_N == !$past(I_PARALLEL_IN[STAGES-1]))
        else $error("inverted output missed loaded bit");

    // Stream words hold until the sink takes them
    chk_stream_hold: assert property (
        @(posedge I_MCLK) disable iff (!rst_sync_r)
        (O_STREAM_VALID && !I_STREAM_READY) |=> O_STREAM_VALID && $stable(O_STREAM_DATA))
        else $error("stream word changed before taken");
endmodule : parallel_to_serial_shifter

// ### core/shifter_pkg.sv
package shifter_pkg;
    localparam int          STAGE_COUNT  = 8;
    localparam int          FIFO_DEPTH   = 16;
    localparam int          STREAM_WIDTH = 1;
    localparam logic [7:0]  STAGE_RESET  = 8'h00;
    localparam logic        PREV_CLK_RST = 1'h1;
    localparam logic        SYNC_RST_VAL = 1'h0;

    // Pin group driven by the controller
    typedef struct packed {
        logic load_n;
        logic serial_in;
        logic shift_clock_a;
        logic shift_clock_b;
    } shift_ctl_t;

    // One word of the serial stream
    typedef struct packed {
        logic [STREAM_WIDTH-1:0] bits;
    } stream_word_t;
endpackage : shifter_pkg

// ### core/stream_fifo.sv
`timescale 1ns/1ps
module stream_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_r, wr_nxt, rd_r, rd_nxt;
    logic [AW:0]      cnt_r, cnt_nxt;
    logic             push, pop;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
    endfunction : bump

    assign in_ready  = (cnt_r != (AW + 1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem_r[rd_r];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        wr_nxt  = push ? bump(wr_r) : wr_r;
        rd_nxt  = pop ? bump(rd_r) : rd_r;
        cnt_nxt = cnt_r + (AW + 1)'(push) - (AW + 1)'(pop);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
        end else begin
            wr_r  <= wr_nxt;
            rd_r  <= rd_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Storage needs no reset
    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wr_r] <= in_data;
        end
    end
endmodule : stream_fifo

// ### test/stream_sink.sv
`timescale 1ns/1ps
module stream_sink
    import shifter_pkg::*;
(
    // Clock
    input  wire logic                    clk,
    // Stream from the shifter
    input  wire logic                    i_en,
    input  wire logic                    i_valid,
    input  wire logic [STREAM_WIDTH-1:0] i_data,
    output logic                         o_ready
);
    stream_word_t got[$];
    logic         coin;
    initial o_ready = 1'h0;
    // Ready wanders randomly so the shifter sees stalls
    always @(posedge clk) begin
        coin = i_en & 1'($urandom_range(0, 1));
        #1 o_ready <= coin;
    end
    // Take words midway, where valid, data and ready all stand
    always @(negedge clk) begin
        if (o_ready && i_valid)
            got.push_back(i_data);
    end
endmodule : stream_sink

// ### test/testbench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module testbench;
    import shifter_pkg::*;
    logic                    clk, rst_n, ld_n, ser, ca, cb, rdy, sink_en;
    logic [7:0]              par, exp_bits, stg;
    logic                    last, last_n, s_valid, space;
    logic [STREAM_WIDTH-1:0] s_data;
    logic                    exp_q[$];
    int                      errors, tests_run, n;

    parallel_to_serial_shifter DUT (
        .I_MCLK(clk), .I_RST_N(rst_n), .I_LOAD_N(ld_n), .I_SERIAL_IN(ser),
        .I_SHIFT_CLOCK_A(ca), .I_SHIFT_CLOCK_B(cb), .I_PARALLEL_IN(par),
        .O_STAGE_BITS(stg), .O_LAST_STAGE_OUT(last), .O_LAST_STAGE_OUT_N(last_n),
        .O_STREAM_VALID(s_valid), .I_STREAM_READY(rdy), .O_STREAM_DATA(s_data),
        .O_STREAM_SPACE(space));
    stream_sink sink (.clk(clk), .i_en(sink_en), .i_valid(s_valid), .i_data(s_data),
        .o_ready(rdy));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic pins(input logic l, s, a, b, input logic [7:0] p);
        @(posedge clk);
        #1 {ld_n, ser, ca, cb, par} = {l, s, a, b, p};
        repeat (3) @(posedge clk);
        #1;
    endtask : pins

    // Expected stage contents after one shift
    function automatic logic [7:0] shifted(input logic [7:0] b, input logic s);
        return {b[6:0], s};
    endfunction : shifted

    task automatic check_out;
        `CHK(stg, exp_bits)
        `CHK(last, exp_bits[7])
        `CHK(last_n, ~exp_bits[7])
    endtask : check_out

    // Both pins low first, then one rises; pin B rising also covers inhibit rise
    task automatic shift(input logic use_a, input logic s);
        pins(1'b1, s, 1'b0, 1'b0, par);
        if (space === 1'b1)
            exp_q.push_back(exp_bits[7]);
        pins(1'b1, s, use_a, ~use_a, par);
        exp_bits = shifted(exp_bits, s);
        check_out();
    endtask : shift

    task wrap_up;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up

    initial begin
        #200000;
        errors++;
        wrap_up();
    end

    initial begin
        {rst_n, ld_n, ser, ca, cb, par, sink_en} = {1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00, 1'b1};
        void'($urandom(30087));
        repeat (20) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge clk);
        #1 exp_bits = STAGE_RESET;
        check_out();
        for (n = 0; n < 4; n++) begin
            // All ones and all zeros first, then random patterns
            exp_bits = (n == 0) ? 8'hFF : (n == 1) ? 8'h00 : 8'($urandom);
            pins(1'b0, 1'b0, 1'b0, 1'b0, exp_bits);
            check_out();
        end
        // Clock rises and data changes while loading
        exp_bits = 8'($urandom);
        pins(1'b0, 1'b1, 1'b1, 1'b1, exp_bits);
        check_out();
        pins(1'b1, 1'b1, 1'b1, 1'b1, exp_bits);
        check_out();
        for (n = 0; n < 40; n++)
            shift(1'($urandom_range(0, 1)), 1'($urandom_range(0, 1)));
        // One pin held high blocks toggles of the other
        pins(1'b1, 1'b0, 1'b1, 1'b0, par);
        pins(1'b1, 1'b1, 1'b1, 1'b1, par);
        pins(1'b1, 1'b0, 1'b0, 1'b1, par);
        pins(1'b1, 1'b1, 1'b1, 1'b1, par);
        check_out();
        // Let earlier words drain so the output register starts empty
        repeat (40) @(posedge clk);
        #1 `CHK(s_valid, 1'h0)
        // Stalled sink: output register holds one word, the buffer the rest
        sink_en = 1'h0;
        repeat (30) @(posedge clk);
        for (n = 0; n <= FIFO_DEPTH; n++) begin
            if (n == FIFO_DEPTH)
                `CHK(space, 1'h1)
            shift(1'($urandom_range(0, 1)), 1'($urandom_range(0, 1)));
        end
        `CHK(space, 1'h0)
        `CHK(s_valid, 1'h1)
        sink_en = 1'b1;
        repeat (120) @(posedge clk);
        #1 `CHK(s_valid, 1'b0)
        `CHK(sink.got.size(), exp_q.size())
        for (n = 0; n < exp_q.size() && n < sink.got.size(); n++)
            `CHK(sink.got[n].bits, exp_q[n])
        wrap_up();
    end
endmodule : testbench
